// ---- btw_params.svh ----
// timing, speed, register offset and reset constants for the body timer block
`ifndef BTW_PARAMS_SVH
`define BTW_PARAMS_SVH
`define BTW_CLK_KHZ         100000
`define BTW_TICK_MS         10
`define BTW_TK(ms)          (((ms) + `BTW_TICK_MS - 1) / `BTW_TICK_MS)
`define BTW_INT_MIN_MS      1500
`define BTW_INT_MAX_MS      20000
`define BTW_WASH_MS         600
`define BTW_WIPE_MS         1000
`define BTW_WASH_WIPES      2'h3
`define BTW_ROOM_HOLD_MS    2000
`define BTW_ROOM_FADE_MS    3000
`define BTW_WIN_MS          30000
`define BTW_DEFOG_LONG_MS   720000
`define BTW_DEFOG_SHORT_MS  360000
`define BTW_DEFOG_MEM_MS    600000
`define BTW_BELT_MS         6000
`define BTW_BLINK_MS        300
`define BTW_KEYHOLE_MS      10000
`define BTW_RELAY_MS        500
`define BTW_RKE_LOCK_MIN_MS 30
`define BTW_RKE_LOCK_MAX_MS 70
`define BTW_RKE_UNL_MIN_MS  80
`define BTW_RKE_UNL_MAX_MS  120
`define BTW_MOVE_KMH        8'h05
`define BTW_AUTOLOCK_KMH    8'h32
`define BTW_CRASH_KMH       8'h0f
`define BTW_CTRL_OFS        12'h000
`define BTW_WINT_OFS        12'h004
`define BTW_STAT_OFS        12'h008
`define BTW_CTRL_RST        32'h00000001
`define BTW_WINT_RST        12'h1f4
`define BTW_CTRL_ROOM_BIT   0
`define BTW_NTMR            8
`endif

// ---- btw_pkg.sv ----
// types shared by the body timer block
package btw_pkg;
    typedef enum logic [3:0] {
        WP_IDLE  = 4'h1,
        WP_WAIT  = 4'h2,
        WP_WIPE  = 4'h4,
        WP_PAUSE = 4'h8
    } btw_wiper_e;
    typedef enum logic [2:0] {
        LK_IDLE   = 3'h1,
        LK_LOCK   = 3'h2,
        LK_UNLOCK = 3'h4
    } btw_lock_e;
    typedef logic [16:0] btw_tmr_t;
endpackage : btw_pkg

// ---- btw_body_ctrl.sv ----
// body timer and warning controller with apb register slave
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "btw_params.svh"

// How it works
// (R1) wiper pause set from interval, 1.5-20 s
// (R2) washer with ignition two starts wiper quickly
// (R3) three more wipes after washer releases
// (R4) room lamp: door open, hold 2s, fade 3s
// (R5) windows enabled 30 s after ignition one off
// (R6) driver or passenger door opening restarts the 30 s window
// (R7) defogger press with engine runs 12 min
// (R8) second press stops defogger at once
// (R9) press within 10 min after long gives 6
// (R10) belt unfastened at ignition: lamp, chime 6 s
// (R11) parking brake lamp flashes while moving
// (R12) tail lamps and driver door: buzzer, unlock
// (R13) ajar lamp blinks while moving, door open
// (R14) key in and driver door: chime, unlock
// (R15) driver/passenger lock switch drives all doors
// (R16) remote commands act only without key
// (R17) remote lock 50 ms, unlock 100 ms pulses
// (R18) key hole lamp on, off 10 s later
// (R19) at 50 km/h unlocked doors lock
// (R20) crash above 15 km/h unlocks doors
// (R21) all timing from one 10 ms tick
module btw_body_ctrl #(
    parameter int TICK_CYC = `BTW_TICK_MS * `BTW_CLK_KHZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        ignition_line_one,
    input  wire logic        ignition_line_two,
    input  wire logic        engine_run,
    input  wire logic        key_in,
    input  wire logic        wiper_int_sw,
    input  wire logic        washer_sw,
    input  wire logic        drv_door_open,
    input  wire logic        pas_door_open,
    input  wire logic        rear_door_open,
    input  wire logic        drv_lock_sw,
    input  wire logic        drv_unlock_sw,
    input  wire logic        pas_lock_sw,
    input  wire logic        pas_unlock_sw,
    input  wire logic        doors_locked,
    input  wire logic        defog_sw,
    input  wire logic        belt_fastened,
    input  wire logic        pbrake_on,
    input  wire logic        tail_sw,
    input  wire logic        crash_in,
    input  wire logic        rke_in,
    input  wire logic [7:0]  speed_kmh,
    output logic             wiper_relay,
    output logic             room_lamp,
    output logic             pwin_enable,
    output logic             defog_relay,
    output logic             belt_lamp,
    output logic             chime,
    output logic             buzzer,
    output logic             pbrake_lamp,
    output logic             ajar_lamp,
    output logic             keyhole_lamp,
    output logic             lock_relay,
    output logic             unlock_relay
);
    localparam int TW = 0, TR = 1, TP = 2, TD = 3, TM = 4, TB = 5, TK = 6, TL = 7;
    localparam btw_pkg::btw_tmr_t WASH_TK  = 17'(`BTW_TK(`BTW_WASH_MS));
    localparam btw_pkg::btw_tmr_t WIPE_TK  = 17'(`BTW_TK(`BTW_WIPE_MS));
    localparam btw_pkg::btw_tmr_t FADE_TK  = 17'(`BTW_TK(`BTW_ROOM_FADE_MS));
    localparam btw_pkg::btw_tmr_t ROOM_TK  = 17'(`BTW_TK(`BTW_ROOM_HOLD_MS + `BTW_ROOM_FADE_MS));
    localparam btw_pkg::btw_tmr_t WIN_TK   = 17'(`BTW_TK(`BTW_WIN_MS));
    localparam btw_pkg::btw_tmr_t LONG_TK  = 17'(`BTW_TK(`BTW_DEFOG_LONG_MS));
    localparam btw_pkg::btw_tmr_t SHORT_TK = 17'(`BTW_TK(`BTW_DEFOG_SHORT_MS));
    localparam btw_pkg::btw_tmr_t MEM_TK   = 17'(`BTW_TK(`BTW_DEFOG_MEM_MS));
    localparam btw_pkg::btw_tmr_t BELT_TK  = 17'(`BTW_TK(`BTW_BELT_MS));
    localparam btw_pkg::btw_tmr_t KEYH_TK  = 17'(`BTW_TK(`BTW_KEYHOLE_MS));
    localparam btw_pkg::btw_tmr_t RELAY_TK = 17'(`BTW_TK(`BTW_RELAY_MS));
    localparam logic [11:0] INT_MIN = 12'(`BTW_TK(`BTW_INT_MIN_MS));
    localparam logic [11:0] INT_MAX = 12'(`BTW_TK(`BTW_INT_MAX_MS));
    localparam logic [5:0]  BLINK_TK = 6'(`BTW_TK(`BTW_BLINK_MS));
    localparam logic [4:0]  RK_L0 = 5'(`BTW_TK(`BTW_RKE_LOCK_MIN_MS));
    localparam logic [4:0]  RK_L1 = 5'(`BTW_TK(`BTW_RKE_LOCK_MAX_MS));
    localparam logic [4:0]  RK_U0 = 5'(`BTW_TK(`BTW_RKE_UNL_MIN_MS));
    localparam logic [4:0]  RK_U1 = 5'(`BTW_TK(`BTW_RKE_UNL_MAX_MS));

    function automatic logic ofs_hit(input logic [11:0] a, input logic [11:0] o);
        ofs_hit = (a == o);
    endfunction : ofs_hit

    logic [31:0]             tick_cnt_reg;
    logic                    tick_reg;
    logic [5:0]              blink_cnt_reg;
    logic                    blink_reg;
    logic [4:0]              pwm_reg;
    logic [31:0]             ctrl_reg;
    logic [11:0]             wint_reg;
    logic [11:0]             wint_eff;
    btw_pkg::btw_tmr_t       tmr_reg [`BTW_NTMR];
    logic [`BTW_NTMR-1:0]    ld;
    btw_pkg::btw_tmr_t       ldv     [`BTW_NTMR];
    btw_pkg::btw_wiper_e     wp_reg;
    btw_pkg::btw_wiper_e     wp_next;
    logic [1:0]              wash_left_reg;
    btw_pkg::btw_lock_e      lk_reg;
    logic                    long_run_reg;
    logic [4:0]              rke_cnt_reg;
    logic                    autolocked_reg;
    logic [15:0]             prev_reg;
    logic                    req_lock;
    logic                    req_unlock;
    logic                    rke_lock;
    logic                    rke_unlock;
    logic                    any_open;
    logic                    moving;
    logic                    defog_press;
    logic                    apb_wr;
    logic                    hit;

    // 10 ms tick; every timer below counts this tick only, except pwm_reg, which counts every pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 32'h0;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == 32'(TICK_CYC - 1)) begin
            tick_cnt_reg <= 32'h0; // R21
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
            tick_reg     <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_reg <= 6'h0;
            blink_reg     <= 1'b0;
            pwm_reg       <= 5'h0;
        end else begin
            pwm_reg <= pwm_reg + 5'h1;
            if (tick_reg) begin
                if (blink_cnt_reg == BLINK_TK - 6'h1) begin
                    blink_cnt_reg <= 6'h0;
                    blink_reg     <= ~blink_reg;
                end else begin
                    blink_cnt_reg <= blink_cnt_reg + 6'h1;
                end
            end
        end
    end

    // input history for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 16'h0;
        end else begin
            prev_reg <= {ignition_line_one, washer_sw, drv_door_open, pas_door_open,
                         drv_lock_sw, drv_unlock_sw, pas_lock_sw, pas_unlock_sw,
                         defog_sw, rke_in, crash_in, 5'h0};
        end
    end

    assign any_open    = drv_door_open | pas_door_open | rear_door_open;
    assign moving      = speed_kmh >= `BTW_MOVE_KMH;
    assign defog_press = defog_sw & ~prev_reg[7];
    assign wint_eff    = (wint_reg < INT_MIN) ? INT_MIN :
                         (wint_reg > INT_MAX) ? INT_MAX : wint_reg; // R1

    // one tick-driven down counter per function
    genvar gi;
    generate
        for (gi = 0; gi < `BTW_NTMR; gi++) begin : g_tmr
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tmr_reg[gi] <= 17'h0;
                end else if (ld[gi]) begin
                    tmr_reg[gi] <= ldv[gi];
                end else if (tick_reg && tmr_reg[gi] != 17'h0) begin
                    tmr_reg[gi] <= tmr_reg[gi] - 17'h1; // R21
                end
            end
        end
    endgenerate

    always_comb begin
        wp_next = wp_reg;
        ld      = '0;
        for (int i = 0; i < `BTW_NTMR; i++) begin
            ldv[i] = 17'h0;
        end
        case (wp_reg)
            btw_pkg::WP_IDLE: begin
                if (ignition_line_two && washer_sw && !prev_reg[14]) begin
                    wp_next = btw_pkg::WP_WAIT; // R2
                    ld[TW]  = 1'b1;
                    ldv[TW] = WASH_TK;
                end else if (ignition_line_two && wiper_int_sw) begin
                    wp_next = btw_pkg::WP_WIPE;
                    ld[TW]  = 1'b1;
                    ldv[TW] = WIPE_TK;
                end
            end
            btw_pkg::WP_WAIT: begin
                if (tmr_reg[TW] == 17'h0) begin
                    wp_next = btw_pkg::WP_WIPE; // R2
                    ld[TW]  = 1'b1;
                    ldv[TW] = WIPE_TK;
                end
            end
            btw_pkg::WP_WIPE: begin
                if (tmr_reg[TW] == 17'h0) begin
                    if (washer_sw || wash_left_reg != 2'h0) begin
                        ld[TW]  = 1'b1; // R3
                        ldv[TW] = WIPE_TK;
                    end else if (wiper_int_sw) begin
                        wp_next = btw_pkg::WP_PAUSE;
                        ld[TW]  = 1'b1; // R1
                        ldv[TW] = 17'(wint_eff);
                    end else begin
                        wp_next = btw_pkg::WP_IDLE;
                    end
                end
            end
            btw_pkg::WP_PAUSE: begin
                if (washer_sw && !prev_reg[14]) begin
                    wp_next = btw_pkg::WP_WAIT;
                    ld[TW]  = 1'b1;
                    ldv[TW] = WASH_TK;
                end else if (!wiper_int_sw) begin
                    wp_next = btw_pkg::WP_IDLE;
                end else if (tmr_reg[TW] == 17'h0) begin
                    wp_next = btw_pkg::WP_WIPE;
                    ld[TW]  = 1'b1;
                    ldv[TW] = WIPE_TK;
                end
            end
            default: wp_next = btw_pkg::WP_IDLE;
        endcase
        if (!ignition_line_two) begin
            wp_next = btw_pkg::WP_IDLE;
        end
        // door open keeps the room timer full; closing starts hold then fade
        ld[TR]  = any_open & ctrl_reg[`BTW_CTRL_ROOM_BIT]; // R4
        ldv[TR] = ROOM_TK;
        ld[TP]  = (!ignition_line_one && prev_reg[15]) // R5
                  || (tmr_reg[TP] != 17'h0 && ((drv_door_open && !prev_reg[13])
                      || (pas_door_open && !prev_reg[12]))); // R6
        ldv[TP] = WIN_TK;
        if (defog_press && tmr_reg[TD] != 17'h0) begin
            ld[TD] = 1'b1; // R8
        end else if (defog_press && engine_run) begin
            ld[TD]  = 1'b1; // R7
            ldv[TD] = (tmr_reg[TM] != 17'h0) ? SHORT_TK : LONG_TK; // R9
        end
        ld[TM]  = tick_reg && long_run_reg && tmr_reg[TD] == 17'h1; // R9
        ldv[TM] = MEM_TK;
        ld[TB]  = ignition_line_one && !prev_reg[15] && !belt_fastened; // R10
        ldv[TB] = BELT_TK;
        ld[TK]  = drv_door_open; // R18
        ldv[TK] = KEYH_TK;
        ld[TL]  = (req_lock || req_unlock) && lk_reg == btw_pkg::LK_IDLE;
        ldv[TL] = RELAY_TK;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_reg        <= btw_pkg::WP_IDLE;
            wash_left_reg <= 2'h0;
        end else begin
            wp_reg <= wp_next;
            if (wp_reg == btw_pkg::WP_WAIT || washer_sw) begin
                wash_left_reg <= `BTW_WASH_WIPES; // R3
            end else if (wp_reg == btw_pkg::WP_WIPE && tmr_reg[TW] == 17'h0
                         && wash_left_reg != 2'h0) begin
                wash_left_reg <= wash_left_reg - 2'h1;
            end
        end
    end

    // defogger: remember whether the current run is the long one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            long_run_reg <= 1'b0;
        end else if (ld[TD]) begin
            long_run_reg <= ldv[TD] == LONG_TK; // R9
        end
    end

    // remote pulse width in ticks, classified on its falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rke_cnt_reg <= 5'h0;
        end else if (!rke_in) begin
            rke_cnt_reg <= 5'h0;
        end else if (tick_reg && rke_cnt_reg != 5'h1f) begin
            rke_cnt_reg <= rke_cnt_reg + 5'h1;
        end
    end
    assign rke_lock   = !rke_in && prev_reg[6] && rke_cnt_reg >= RK_L0
                        && rke_cnt_reg <= RK_L1; // R17
    assign rke_unlock = !rke_in && prev_reg[6] && rke_cnt_reg >= RK_U0
                        && rke_cnt_reg <= RK_U1; // R17

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            autolocked_reg <= 1'b0;
        end else if (speed_kmh < `BTW_AUTOLOCK_KMH) begin
            autolocked_reg <= 1'b0;
        end else if (!doors_locked) begin
            autolocked_reg <= 1'b1;
        end
    end

    // unlock outranks lock: a simultaneous lock request never masks an unlock
    assign req_unlock = (drv_unlock_sw && !prev_reg[10]) || (pas_unlock_sw && !prev_reg[8]) // R15
                        || (!key_in && rke_unlock) // R16
                        || (crash_in && !prev_reg[5] && speed_kmh > `BTW_CRASH_KMH) // R20
                        || (drv_door_open && !prev_reg[13] && doors_locked
                            && (tail_sw || key_in)); // R12 R14
    assign req_lock   = (drv_lock_sw && !prev_reg[11]) || (pas_lock_sw && !prev_reg[9]) // R15
                        || (!key_in && rke_lock) // R16
                        || (!autolocked_reg && !doors_locked
                            && speed_kmh >= `BTW_AUTOLOCK_KMH); // R19

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk_reg <= btw_pkg::LK_IDLE;
        end else begin
            case (lk_reg)
                btw_pkg::LK_IDLE: begin
                    if (req_unlock) begin
                        lk_reg <= btw_pkg::LK_UNLOCK;
                    end else if (req_lock) begin
                        lk_reg <= btw_pkg::LK_LOCK;
                    end
                end
                btw_pkg::LK_LOCK, btw_pkg::LK_UNLOCK: begin
                    if (tmr_reg[TL] == 17'h0) begin
                        lk_reg <= btw_pkg::LK_IDLE;
                    end
                end
                default: lk_reg <= btw_pkg::LK_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wiper_relay  <= 1'b0;
            room_lamp    <= 1'b0;
            pwin_enable  <= 1'b0;
            defog_relay  <= 1'b0;
            belt_lamp    <= 1'b0;
            chime        <= 1'b0;
            buzzer       <= 1'b0;
            pbrake_lamp  <= 1'b0;
            ajar_lamp    <= 1'b0;
            keyhole_lamp <= 1'b0;
            lock_relay   <= 1'b0;
            unlock_relay <= 1'b0;
        end else begin
            wiper_relay  <= wp_reg == btw_pkg::WP_WIPE;
            // fade by pwm duty shrinking with the remaining fade time
            room_lamp    <= tmr_reg[TR] > FADE_TK
                            || (tmr_reg[TR] != 17'h0 && pwm_reg < tmr_reg[TR][8:4]); // R4
            // load term bridges the cycle in which the timer is still empty
            pwin_enable  <= ignition_line_one || ld[TP] || tmr_reg[TP] != 17'h0; // R5
            defog_relay  <= tmr_reg[TD] != 17'h0; // R7
            belt_lamp    <= tmr_reg[TB] != 17'h0; // R10
            chime        <= blink_reg && (tmr_reg[TB] != 17'h0
                                          || (drv_door_open && key_in)); // R10 R14
            buzzer       <= blink_reg && drv_door_open && tail_sw; // R12
            pbrake_lamp  <= blink_reg && moving && pbrake_on; // R11
            ajar_lamp    <= blink_reg && moving && any_open; // R13
            keyhole_lamp <= drv_door_open || tmr_reg[TK] != 17'h0; // R18
            lock_relay   <= lk_reg == btw_pkg::LK_LOCK;
            unlock_relay <= lk_reg == btw_pkg::LK_UNLOCK;
        end
    end

    // apb slave: answer prepared in setup, so access phase completes at once
    assign hit    = ofs_hit(paddr, `BTW_CTRL_OFS) || ofs_hit(paddr, `BTW_WINT_OFS)
                    || ofs_hit(paddr, `BTW_STAT_OFS);
    assign apb_wr = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= 32'h0;
            if (psel && !penable && !pwrite) begin
                if (ofs_hit(paddr, `BTW_CTRL_OFS)) begin
                    prdata <= ctrl_reg;
                end else if (ofs_hit(paddr, `BTW_WINT_OFS)) begin
                    prdata <= {20'h0, wint_reg};
                end else if (ofs_hit(paddr, `BTW_STAT_OFS)) begin
                    prdata <= {20'h0, wiper_relay, room_lamp, pwin_enable, defog_relay,
                               belt_lamp, chime, buzzer, pbrake_lamp, ajar_lamp,
                               keyhole_lamp, lock_relay, unlock_relay};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `BTW_CTRL_RST;
            wint_reg <= `BTW_WINT_RST;
        end else if (apb_wr && ofs_hit(paddr, `BTW_CTRL_OFS)) begin
            ctrl_reg <= {31'h0, pwdata[`BTW_CTRL_ROOM_BIT]};
        end else if (apb_wr && ofs_hit(paddr, `BTW_WINT_OFS)) begin
            wint_reg <= pwdata[11:0];
        end
    end

    a_win_load: assert property (@(posedge pclk) disable iff (!presetn) // R5
        $fell(ignition_line_one) |=> tmr_reg[TP] == WIN_TK)
        else $error("window timer not loaded on ignition off");
    a_win_door: assert property (@(posedge pclk) disable iff (!presetn) // R6
        tmr_reg[TP] != 17'h0 && ($rose(drv_door_open) || $rose(pas_door_open))
        |=> tmr_reg[TP] == WIN_TK)
        else $error("window timer not restarted by door");
    a_win_out: assert property (@(posedge pclk) disable iff (!presetn) // R5
        tmr_reg[TP] != 17'h0 |=> pwin_enable)
        else $error("windows disabled while timer runs");
    a_defog_stop: assert property (@(posedge pclk) disable iff (!presetn) // R8
        defog_press && tmr_reg[TD] != 17'h0 |=> ##1 !defog_relay)
        else $error("defogger not stopped by second press");
    a_defog_len: assert property (@(posedge pclk) disable iff (!presetn) // R7 R9
        defog_press && engine_run && tmr_reg[TD] == 17'h0
        |=> tmr_reg[TD] == (($past(tmr_reg[TM]) != 17'h0) ? SHORT_TK : LONG_TK))
        else $error("defogger run length wrong");
    a_belt_start: assert property (@(posedge pclk) disable iff (!presetn) // R10
        $rose(ignition_line_one) && !belt_fastened |=> ##1 belt_lamp)
        else $error("belt lamp not lit");
    a_rke_keyed: assert property (@(posedge pclk) disable iff (!presetn) // R16
        lk_reg == btw_pkg::LK_IDLE && key_in && rke_lock && !req_unlock
        && !(drv_lock_sw && !prev_reg[11]) && !(pas_lock_sw && !prev_reg[9])
        && !(!autolocked_reg && !doors_locked && speed_kmh >= `BTW_AUTOLOCK_KMH)
        |=> lk_reg == btw_pkg::LK_IDLE)
        else $error("remote lock acted with key inserted");
    a_lock_pri: assert property (@(posedge pclk) disable iff (!presetn) // R15 R20
        lk_reg == btw_pkg::LK_IDLE && req_unlock |=> lk_reg == btw_pkg::LK_UNLOCK
        ##1 unlock_relay)
        else $error("unlock request not served");
    a_wash_go: assert property (@(posedge pclk) disable iff (!presetn) // R2
        wp_reg == btw_pkg::WP_WAIT && tmr_reg[TW] == 17'h0 && ignition_line_two
        |=> wp_reg == btw_pkg::WP_WIPE ##1 wiper_relay)
        else $error("washer wipe did not start");
    a_keyhole: assert property (@(posedge pclk) disable iff (!presetn) // R18
        drv_door_open |=> keyhole_lamp)
        else $error("key hole lamp off with door open");
    a_park_flash: assert property (@(posedge pclk) disable iff (!presetn) // R11
        !(pbrake_on && moving) |=> !pbrake_lamp)
        else $error("brake lamp flashes without cause");

endmodule : btw_body_ctrl

// ---- btw_remote_model.sv ----
// remote receiver model: one pulse of a given width per request
`timescale 1ns/1ps
module btw_remote_model (
    input  wire logic        pclk,
    input  wire logic        send,
    input  wire logic [15:0] width,
    output logic             rke_in
);
    logic [15:0] cnt_reg = 16'h0000;
    always @(posedge pclk) begin
        if (send) begin
            cnt_reg <= width;
        end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
        end
        rke_in <= send || (cnt_reg > 16'h0001);
    end
endmodule : btw_remote_model

// ---- testbench.sv ----
// self-checking bench for the body timer block
`timescale 1ns/1ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, send, rke_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] width;
    logic [7:0]  speed_kmh;
    logic ignition_line_one, ignition_line_two, engine_run, key_in, wiper_int_sw, washer_sw,
        drv_door_open, pas_door_open, rear_door_open, drv_lock_sw, drv_unlock_sw, pas_lock_sw,
        pas_unlock_sw, doors_locked, defog_sw, belt_fastened, pbrake_on, tail_sw, crash_in,
        wiper_relay, room_lamp, pwin_enable, defog_relay, belt_lamp, chime, buzzer,
        pbrake_lamp, ajar_lamp, keyhole_lamp, lock_relay, unlock_relay, er;
    int n_errors = 0;
    int checked = 0;
    btw_body_ctrl #(.TICK_CYC(10)) btw_body_ctrl_inst (.*);
    btw_remote_model btw_remote_model_inst (.pclk, .send, .width, .rke_in);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wt(ref logic s, input int n);
        for (int i = 0; i < n && s !== 1'b1; i++) @(posedge pclk);
    endtask : wt
    task apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        // no local limit: only the watchdog may end a stalled transfer
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task t_regs;
        apb(0, 12'h000, 0); chk("ctrl", rd, 32'h1);
        apb(0, 12'h004, 0); chk("wint", rd, 32'h1f4);
        apb(1, 12'h004, 32'h64); apb(0, 12'h004, 0); chk("wint_wr", rd, 32'h64);
        apb(0, 12'h00c, 0); chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    endtask : t_regs
    task t_defog;
        @(posedge pclk) {engine_run, defog_sw} <= 2'b11;
        repeat (3) @(posedge pclk); chk("defog_on", defog_relay, 1);
        defog_sw <= 1'b0;
        @(posedge pclk) defog_sw <= 1'b1;
        repeat (3) @(posedge pclk); chk("defog_off", defog_relay, 0);
    endtask : t_defog
    task t_wiper;
        @(posedge pclk) {ignition_line_two, washer_sw} <= 2'b11;
        wt(wiper_relay, 700); chk("wash_go", wiper_relay, 1);
        washer_sw <= 1'b0;
        repeat (3900) @(posedge pclk); chk("wash_more", wiper_relay, 1);
        repeat (200) @(posedge pclk); chk("wash_stop", wiper_relay, 0);
        ignition_line_two <= 1'b0;
    endtask : t_wiper
    task t_window;
        @(posedge pclk) ignition_line_one <= 1'b1;
        @(posedge pclk) ignition_line_one <= 1'b0;
        repeat (3) @(posedge pclk); chk("pwin_on", pwin_enable, 1);
        chk("belt", belt_lamp, 1);
        repeat (20000) @(posedge pclk); drv_door_open <= 1'b1;
        @(posedge pclk) drv_door_open <= 1'b0;
        repeat (2) @(posedge pclk); chk("keyhole", keyhole_lamp, 1);
        chk("room", room_lamp, 1);
        repeat (29898) @(posedge pclk); chk("pwin_ext", pwin_enable, 1);
        chk("keyhole_off", keyhole_lamp, 0);
        chk("room_off", room_lamp, 0);
        repeat (300) @(posedge pclk); chk("pwin_end", pwin_enable, 0);
    endtask : t_window
    task t_locks;
        @(posedge pclk) drv_lock_sw <= 1'b1;
        wt(lock_relay, 10); chk("central", lock_relay, 1);
        drv_lock_sw <= 1'b0;
        repeat (700) @(posedge pclk);
        {send, width} <= {1'b1, 16'd100};
        @(posedge pclk) send <= 1'b0;
        wt(unlock_relay, 200); chk("rke_unl", unlock_relay, 1);
        repeat (700) @(posedge pclk);
        {key_in, send, width} <= {2'b11, 16'd50};
        @(posedge pclk) send <= 1'b0;
        repeat (200) @(posedge pclk); chk("rke_key", lock_relay, 0);
    endtask : t_locks
    task t_warn;
        @(posedge pclk) {speed_kmh, pbrake_on, drv_door_open, tail_sw} <= {8'h14, 3'b111};
        wt(pbrake_lamp, 700); chk("pbrake", pbrake_lamp, 1);
        wt(ajar_lamp, 700); chk("ajar", ajar_lamp, 1);
        wt(chime, 700); chk("key_chime", chime, 1);
        chk("tail_buzz", buzzer, 1);
    endtask : t_warn
    task report_and_stop;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, send, width, speed_kmh} = '0;
        {ignition_line_one, ignition_line_two, engine_run, key_in, wiper_int_sw, washer_sw,
            drv_door_open, pas_door_open, rear_door_open, drv_lock_sw, drv_unlock_sw,
            pas_lock_sw, pas_unlock_sw, doors_locked, defog_sw, belt_fastened, pbrake_on,
            tail_sw, crash_in} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs; t_defog; t_wiper; t_window; t_locks; t_warn;
        report_and_stop;
    end
    initial begin
        repeat (90000) @(posedge pclk);
        n_errors++;
        report_and_stop;
    end
endmodule : testbench
